/* bench/dspli_term_model.sv */
// Purpose: Remote terminal model for one serial line
// Assumes: Sends 8N1 frames, samples eight bits after each start bit
// Notes: A seven-bit frame shows its parity bit as bit 7 of rx_byte
`timescale 1ns/1ps
`default_nettype none
module dspli_term_model (
  // Clock and bit time in cycles
  input wire logic clk,
  input wire logic [15:0] div,
  // Serial lines
  input wire logic line_in,
  output logic line_out,
  // Captured characters
  output logic [7:0] rx_byte,
  output int rx_cnt
);
  initial begin
    line_out = 1'b1;
    rx_byte = 8'h00;
    rx_cnt = 0;
  end
  // ==========================================================================
  // Sending: start low, data LSB first, one stop high
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (div) @(posedge clk);
    end
  endtask
  // ==========================================================================
  // Receiving: mid-bit sampling keeps clear of edge jitter
  always begin
    @(negedge line_in);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      rx_byte[i] = line_in;
    end
    repeat (div) @(posedge clk);
    rx_cnt++;
  end
endmodule
`default_nettype wire

/* bench/dspli_top_monitor.sv */
// Purpose: Bus and serial line timing checks
// Assumes: Sees only top-level ports
// Notes: Bit checks need every bit time of at least eight cycles
`timescale 1ns/1ps
`default_nettype none
module dspli_top_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial outputs
  input wire logic pri_txd,
  input wire logic [2:0] aux_txd
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic take = hsel & htrans[1] & hready;
  wire logic rd_take = take & ~hwrite;
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence pri_hold;
    $stable(pri_txd) [*7];
  endsequence
  sequence aux_hold;
    $stable(aux_txd) [*7];
  endsequence
  // ==========================================================================
  // Assertions
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  rd_wait_a: assert property (rd_take |=> one_wait)
    else $error("read did not take exactly one wait state");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  wait_cause_a: assert property (!hreadyout |-> $past(rd_take))
    else $error("wait state without a read");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  aux_route_a: assert property ($countones(~aux_txd) <= 1)
    else $error("more than one aux interface active");
  pri_bit_a: assert property ($changed(pri_txd) |=> pri_hold)
    else $error("primary bit too short");
  aux_bit_a: assert property ($changed(aux_txd) |=> aux_hold)
    else $error("aux bit too short");
endmodule
bind dspli_top dspli_top_monitor u_mon (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pri_txd(pri_txd), .aux_txd(aux_txd)
);
`default_nettype wire

/* bench/dspli_top_tb.sv */
// Purpose: Self-checking bench for the dual serial port block
// Assumes: Clock parameter cut to 2.5 MHz, 25-cycle millisecond
// Notes: Terminal models sit on the primary and RS-232 aux lines
`timescale 1ns/1ps
`default_nettype none
`include "dspli_consts.vh"
module dspli_top_tb;
  // ==========================================================================
  // Signals
  localparam int DIV = 260;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pri_flow_in = 1'b1;
  logic aux_flow_in = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, pri_rxd, pri_txd, pri_flow_out, aux_line;
  wire logic aux_flow_out, aux_drive_en;
  wire logic [2:0] aux_txd;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #20 clk = ~clk;
  dspli_top #(.CLK_HZ(2500000), .MS_CYCLES(25)) u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pri_rxd(pri_rxd), .pri_txd(pri_txd), .pri_flow_in(pri_flow_in),
    .pri_flow_out(pri_flow_out), .aux_rxd({2'b11, aux_line}), .aux_txd(aux_txd),
    .aux_flow_in(aux_flow_in), .aux_flow_out(aux_flow_out), .aux_drive_en(aux_drive_en)
  );
  dspli_term_model u_pri (.clk(clk), .div(16'd260), .line_in(pri_txd), .line_out(pri_rxd),
    .rx_byte(), .rx_cnt());
  dspli_term_model u_aux (.clk(clk), .div(16'd260), .line_in(aux_txd[0]), .line_out(aux_line),
    .rx_byte(), .rx_cnt());
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    haddr <= {22'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic snd(input logic [7:0] c);
    u_pri.send(c);
    repeat (DIV) @(posedge clk);
  endtask
  task automatic wait_rx(input int k);
    while (u_pri.rx_cnt < k) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run of about 75000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(`DSPLI_PRI_CFG, 32'h085);
    rc(`DSPLI_AUX_CFG, 32'h085);
    rc(`DSPLI_IN_CFG, 32'h000d00);
    rc(`DSPLI_IN_WAIT, 32'h0);
    rc(10'h3fc, 32'h0);
    wr(`DSPLI_TX_DATA, 32'h13c);
    while (u_aux.rx_cnt < 1) @(posedge clk);
    chk({24'h0, u_aux.rx_byte}, 32'h03c);
    for (int i = 0; i < 8; i++) begin
      n = i % 3;
      wr(`DSPLI_PRI_CFG, 32'(32'h400 | (n << 7) | (n << 3) | i));
      rc(`DSPLI_PRI_CFG, 32'((n << 7) | (n << 3) | i));
    end
    rc(`DSPLI_AUX_CFG, 32'h085);
    wr(`DSPLI_PRI_CFG, 32'h06d);
    wr(`DSPLI_TX_DATA, 32'h043);
    wait_rx(1);
    chk({24'h0, u_pri.rx_byte}, 32'h0c3);
    // Echo and editing, with the terminator ending the line
    wr(`DSPLI_PRI_CFG, 32'h005);
    wr(`DSPLI_IN_CTRL, 32'h1);
    snd(8'h41);
    snd(8'h42);
    snd(8'h08);
    snd(8'h43);
    snd(8'h0d);
    wait_rx(6);
    chk({24'h0, u_pri.rx_byte}, 32'h00d);
    rc(`DSPLI_STATUS, 32'h010202);
    rc(`DSPLI_BUF_BASE, 32'h41);
    rc(10'h204, 32'h43);
    // Length limit with editing and echo off
    wr(`DSPLI_IN_CFG, 32'h020d03);
    wr(`DSPLI_IN_CTRL, 32'h1);
    snd(8'h08);
    snd(8'h7f);
    rc(`DSPLI_STATUS, 32'h010204);
    rc(`DSPLI_BUF_BASE, 32'h08);
    rc(10'h204, 32'h7f);
    chk(32'(u_pri.rx_cnt), 32'd6);
    // Timeouts; ticks are coarse, so allow twice the setting
    wr(`DSPLI_IN_CFG, 32'h000d01);
    wr(`DSPLI_IN_WAIT, 32'h3);
    wr(`DSPLI_IN_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    rc(`DSPLI_STATUS, 32'h010008);
    wr(`DSPLI_IN_WAIT, 32'h20000);
    wr(`DSPLI_IN_CTRL, 32'h1);
    snd(8'h78);
    repeat (150) @(posedge clk);
    rc(`DSPLI_STATUS, 32'h010110);
    // Software pause and resume
    wr(`DSPLI_PRI_CFG, 32'h085);
    snd(8'h13);
    wr(`DSPLI_TX_DATA, 32'h05a);
    // Twelve bit times outlast one whole frame, so a leak would show
    repeat (12 * DIV) @(posedge clk);
    chk(32'(u_pri.rx_cnt), 32'd6);
    snd(8'h11);
    wait_rx(7);
    chk({24'h0, u_pri.rx_byte}, 32'h05a);
    // Hardware flow control holds the sender
    wr(`DSPLI_PRI_CFG, 32'h105);
    pri_flow_in <= 1'b0;
    wr(`DSPLI_TX_DATA, 32'h066);
    repeat (12 * DIV) @(posedge clk);
    chk(32'(u_pri.rx_cnt), 32'd7);
    chk({31'h0, pri_flow_out}, 32'h1);
    pri_flow_in <= 1'b1;
    wait_rx(8);
    chk({24'h0, u_pri.rx_byte}, 32'h066);
    // Interface switch to RS-485; the aux port is held idle while settling
    wr(`DSPLI_AUX_CFG, 32'h285);
    rc(`DSPLI_AUX_CFG, 32'h285);
    rc(`DSPLI_STATUS, 32'h050110);
    // Settle is 1000 ticks of 25 cycles; the sender keeps quiet until then
    repeat (25050) @(posedge clk);
    rc(`DSPLI_STATUS, 32'h010110);
    wr(`DSPLI_TX_DATA, 32'h155);
    repeat (10) @(posedge clk);
    chk({29'h0, aux_txd}, 32'h5);
    chk({31'h0, aux_drive_en}, 32'h1);
    chk({31'h0, aux_flow_out}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire

/* rtl/dspli_consts.vh */
// Purpose: Shared constants for the dual serial port and line input block
// Assumes: 25 MHz system clock, AHB-Lite register access
// Notes: Field macros are bit ranges, usable as vec[`NAME]
`ifndef DSPLI_CONSTS_VH
`define DSPLI_CONSTS_VH

// ==========================================================================
// Timing
`define DSPLI_CLK_HZ 25000000
`define DSPLI_MS_CYCLES (`DSPLI_CLK_HZ / 1000)
`define DSPLI_SETTLE_MS 10'd1000

// ==========================================================================
// Bit rates, indexed by the rate select field
`define DSPLI_BAUD0 300
`define DSPLI_BAUD1 600
`define DSPLI_BAUD2 1200
`define DSPLI_BAUD3 2400
`define DSPLI_BAUD4 4800
`define DSPLI_BAUD5 9600
`define DSPLI_BAUD6 19200
`define DSPLI_BAUD7 57600

// ==========================================================================
// Register byte offsets
`define DSPLI_PRI_CFG 10'h000
`define DSPLI_AUX_CFG 10'h004
`define DSPLI_IN_CFG 10'h008
`define DSPLI_IN_WAIT 10'h00c
`define DSPLI_IN_CTRL 10'h010
`define DSPLI_TX_DATA 10'h014
`define DSPLI_STATUS 10'h018
`define DSPLI_BUF_BASE 10'h200

// ==========================================================================
// Port configuration fields and codes
`define DSPLI_F_BAUD 2:0
`define DSPLI_F_PAR 4:3
`define DSPLI_F_SEVEN 5
`define DSPLI_F_TWOSTOP 6
`define DSPLI_F_FLOW 8:7
`define DSPLI_F_IFACE 10:9
`define DSPLI_PAR_NONE 2'd0
`define DSPLI_PAR_EVEN 2'd1
`define DSPLI_PAR_ODD 2'd2
`define DSPLI_FLOW_NONE 2'd0
`define DSPLI_FLOW_SW 2'd1
`define DSPLI_FLOW_HW 2'd2
`define DSPLI_IF_RS232 2'd0
`define DSPLI_IF_RS485 2'd1
`define DSPLI_IF_MODEM 2'd2
`define DSPLI_CFG_RST 11'h085

// ==========================================================================
// Line input fields
`define DSPLI_F_NOECHO 0
`define DSPLI_F_NOEDIT 1
`define DSPLI_F_TERM 15:8
`define DSPLI_F_LEN 22:16
`define DSPLI_F_FIRST 15:0
`define DSPLI_F_NEXT 31:16
`define DSPLI_IN_CFG_RST 23'h000d00
`define DSPLI_F_START 0
`define DSPLI_F_LPORT 1
`define DSPLI_F_TXAUX 8
`define DSPLI_MAX_LEN 7'd79
`define DSPLI_BUF_DEPTH 80

// ==========================================================================
// Characters and done reasons
`define DSPLI_CH_XON 8'h11
`define DSPLI_CH_XOFF 8'h13
`define DSPLI_CH_BS 8'h08
`define DSPLI_CH_DEL 8'h7f
`define DSPLI_WHY_TERM 4'h1
`define DSPLI_WHY_LEN 4'h2
`define DSPLI_WHY_FIRST 4'h4
`define DSPLI_WHY_NEXT 4'h8

`endif

/* rtl/dspli_line_mem.v */
// Purpose: Line input character store with registered read data
// Assumes: One write port, one read port, same clock
// Notes: Reads beyond the depth return zero
`timescale 1ns/1ps
`default_nettype none
`include "dspli_consts.vh"

module dspli_line_mem (
  // Clock
  input wire clk,
  // Write side
  input wire wen,
  input wire [6:0] waddr,
  input wire [7:0] wdata,
  // Read side
  input wire [6:0] raddr,
  output reg [7:0] q
);
  reg [7:0] mem [0:`DSPLI_BUF_DEPTH-1];

  always @(posedge clk) begin
    if (wen) begin
      mem[waddr] <= wdata;
    end
    q <= (raddr < `DSPLI_BUF_DEPTH) ? mem[raddr] : 8'h00;
  end
endmodule
`default_nettype wire

/* rtl/dspli_top.v */
// Purpose: Two serial ports with a line input receiver, on AHB-Lite
// Assumes: Serial inputs synchronous to clk, single-word bus transfers
// Notes: Reads take one wait state, writes none
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dspli_consts.vh"

module dspli_top #(
  parameter CLK_HZ = `DSPLI_CLK_HZ,
  parameter MS_CYCLES = `DSPLI_MS_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Primary port
  input wire pri_rxd,
  output wire pri_txd,
  input wire pri_flow_in,
  output wire pri_flow_out,
  // Auxiliary port, one line per physical interface
  input wire [2:0] aux_rxd,
  output reg [2:0] aux_txd,
  input wire aux_flow_in,
  output wire aux_flow_out,
  output reg aux_drive_en
);
  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;

  // ========================================================================
  // Registers
  reg [10:0] pri_cfg;
  reg [10:0] aux_cfg;
  reg [22:0] in_cfg;
  reg [31:0] in_wait;
  reg [9:0] a_q;
  reg wr_ph;
  reg rd_ph;
  reg [1:0] lstate;
  reg lport;
  reg [6:0] lcnt;
  reg got;
  reg [15:0] wait_ms;
  reg [3:0] why;
  reg [1:0] echo_req;
  reg [7:0] echo_char;
  reg [1:0] host_wr;
  reg [7:0] host_char;
  reg [16:0] ms_div;
  reg ms_tick;
  reg [9:0] settle;
  wire settling = (settle != 10'd0);
  wire [7:0] rx_char [0:1];
  wire [1:0] rx_v;
  wire [1:0] tx_line;
  wire [1:0] tx_full;
  wire [1:0] paused;
  wire [1:0] tx_busy;
  wire [7:0] mem_q;
  wire aux_rx = aux_rxd[aux_cfg[`DSPLI_F_IFACE]];

  function [16:0] baud_div;
    input [2:0] s;
    reg [31:0] r;
    begin
      case (s)
        3'd0: r = CLK_HZ / `DSPLI_BAUD0;
        3'd1: r = CLK_HZ / `DSPLI_BAUD1;
        3'd2: r = CLK_HZ / `DSPLI_BAUD2;
        3'd3: r = CLK_HZ / `DSPLI_BAUD3;
        3'd4: r = CLK_HZ / `DSPLI_BAUD4;
        3'd5: r = CLK_HZ / `DSPLI_BAUD5;
        3'd6: r = CLK_HZ / `DSPLI_BAUD6;
        default: r = CLK_HZ / `DSPLI_BAUD7;
      endcase
      baud_div = r[16:0];
    end
  endfunction

  // Frame laid out LSB first with idle ones above the stop bits
  function [11:0] frame;
    input [7:0] d;
    input [10:0] c;
    reg par;
    begin
      par = (c[`DSPLI_F_SEVEN] ? ^d[6:0] : ^d) ^ (c[`DSPLI_F_PAR] == `DSPLI_PAR_ODD);
      frame = 12'hfff;
      frame[0] = 1'b0;
      if (c[`DSPLI_F_SEVEN]) begin
        frame[7:1] = d[6:0];
        if (c[`DSPLI_F_PAR] != `DSPLI_PAR_NONE) frame[8] = par;
      end else begin
        frame[8:1] = d;
        if (c[`DSPLI_F_PAR] != `DSPLI_PAR_NONE) frame[9] = par;
      end
    end
  endfunction

  // ========================================================================
  // Serial engines, index 0 primary, 1 auxiliary
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      wire [10:0] cfg = p ? aux_cfg : pri_cfg;
      wire rxd = p ? aux_rx : pri_rxd;
      wire cts = p ? aux_flow_in : pri_flow_in;
      wire hold = p ? settling : 1'b0;
      wire [16:0] div = baud_div(cfg[`DSPLI_F_BAUD]);
      wire has_par = (cfg[`DSPLI_F_PAR] != `DSPLI_PAR_NONE);
      wire [3:0] nbits = 4'd10 - {3'b0, cfg[`DSPLI_F_SEVEN]} + {3'b0, has_par}
        + {3'b0, cfg[`DSPLI_F_TWOSTOP]};
      wire sw = (cfg[`DSPLI_F_FLOW] == `DSPLI_FLOW_SW);
      wire hw = (cfg[`DSPLI_F_FLOW] == `DSPLI_FLOW_HW);
      reg [11:0] rsh;
      wire [7:0] rdat = cfg[`DSPLI_F_SEVEN] ? {1'b0, rsh[7:1]} : rsh[8:1];
      wire [11:0] rref = frame(rdat, cfg);
      wire [3:0] ppos = cfg[`DSPLI_F_SEVEN] ? 4'd8 : 4'd9;
      wire par_ok = !has_par || (rref[ppos] == rsh[ppos]);
      reg [7:0] hdat;
      reg [7:0] edat;
      reg hv;
      reg ev;
      reg [16:0] tcnt;
      reg [11:0] tsh;
      reg [3:0] tbits;
      reg tline;
      reg pz;
      reg rxd_q;
      reg rbusy;
      reg [16:0] rcnt;
      reg [3:0] rk;
      reg rv;
      reg [7:0] rch;
      reg rts;
      assign tx_line[p] = tline;
      assign tx_full[p] = hv;
      assign paused[p] = pz;
      assign rx_v[p] = rv;
      assign rx_char[p] = rch;
      assign tx_busy[p] = (tbits != 4'd0);

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hdat <= 8'h00;
          edat <= 8'h00;
          hv <= 1'b0;
          ev <= 1'b0;
          tcnt <= 17'h00000;
          tsh <= 12'hfff;
          tbits <= 4'h0;
          tline <= 1'b1;
          pz <= 1'b0;
          rxd_q <= 1'b1;
          rbusy <= 1'b0;
          rcnt <= 17'h00000;
          rk <= 4'h0;
          rsh <= 12'h000;
          rv <= 1'b0;
          rch <= 8'h00;
          rts <= 1'b0;
        end else if (hold) begin
          // Interface switch reinitialises everything queued on this port
          hv <= 1'b0;
          ev <= 1'b0;
          tbits <= 4'h0;
          tline <= 1'b1;
          pz <= 1'b0;
          rbusy <= 1'b0;
          rv <= 1'b0;
          rxd_q <= 1'b1;
          rts <= 1'b0;
        end else begin
          rv <= 1'b0;
          rxd_q <= rxd;
          rts <= hw ? !ev : 1'b1;
          // Transmit
          if (tbits != 4'h0) begin
            if (tcnt == 17'h00000) begin
              tcnt <= div - 17'h00001;
              tline <= tsh[0];
              tsh <= {1'b1, tsh[11:1]};
              tbits <= tbits - 4'h1;
            end else begin
              tcnt <= tcnt - 17'h00001;
            end
          end else if ((ev || hv) && !(sw && pz) && !(hw && !cts)) begin
            tsh <= frame(ev ? edat : hdat, cfg);
            tbits <= nbits + 4'h1;
            tcnt <= 17'h00000;
            if (ev) ev <= 1'b0;
            else hv <= 1'b0;
          end
          // A new echo overwrites one still queued
          if (echo_req[p]) begin
            ev <= 1'b1;
            edat <= echo_char;
          end
          // Host writes while full are dropped
          if (host_wr[p] && !hv) begin
            hv <= 1'b1;
            hdat <= host_char;
          end
          // Receive, sampling mid-bit
          if (!rbusy) begin
            if (rxd_q && !rxd) begin
              rbusy <= 1'b1;
              rcnt <= {1'b0, div[16:1]};
              rk <= 4'h0;
            end
          end else if (rcnt != 17'h00000) begin
            rcnt <= rcnt - 17'h00001;
          end else begin
            rcnt <= div - 17'h00001;
            rsh[rk] <= rxd;
            rk <= rk + 4'h1;
            if (rk == 4'h0 && rxd) begin
              rbusy <= 1'b0;
            end else if (rk == nbits - 4'h1 - {3'b0, cfg[`DSPLI_F_TWOSTOP]}) begin
              rbusy <= 1'b0;
              if (rxd && par_ok) begin
                if (sw && rdat == `DSPLI_CH_XOFF) pz <= 1'b1;
                else if (sw && rdat == `DSPLI_CH_XON) pz <= 1'b0;
                else begin
                  rv <= 1'b1;
                  rch <= rdat;
                end
              end
            end
          end
        end
      end
    end
  endgenerate

  assign pri_txd = g_port[0].tline;
  assign pri_flow_out = g_port[0].rts;
  assign aux_flow_out = g_port[1].rts;

  // ========================================================================
  // Auxiliary routing and settle time
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_txd <= 3'b111;
      aux_drive_en <= 1'b0;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        aux_txd[i] <= (aux_cfg[`DSPLI_F_IFACE] == i) ? tx_line[1] : 1'b1;
      end
      aux_drive_en <= (aux_cfg[`DSPLI_F_IFACE] == `DSPLI_IF_RS485) && tx_busy[1];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div <= 17'h00000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == MS_CYCLES - 1);
      if (ms_div == MS_CYCLES - 1) ms_div <= 17'h00000;
      else ms_div <= ms_div + 17'h00001;
    end
  end

  // ========================================================================
  // Bus slave and configuration
  wire [31:0] status = {9'h000, paused, tx_full, settling, aux_flow_in, pri_flow_in,
    1'b0, lcnt, 3'b000, why, lstate[1]};
  wire [31:0] rd_mux = a_q[9] ? {24'h000000, mem_q} :
    (a_q == `DSPLI_PRI_CFG) ? {21'h000000, pri_cfg} :
    (a_q == `DSPLI_AUX_CFG) ? {21'h000000, aux_cfg} :
    (a_q == `DSPLI_IN_CFG) ? {9'h000, in_cfg} :
    (a_q == `DSPLI_IN_WAIT) ? in_wait :
    (a_q == `DSPLI_STATUS) ? status : 32'h00000000;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 10'h000;
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_ph <= 1'b0;
      if (rd_ph) begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
        rd_ph <= 1'b0;
      end
      if (hsel && htrans[1] && hready) begin
        a_q <= haddr[9:0];
        wr_ph <= hwrite;
        rd_ph <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_cfg <= `DSPLI_CFG_RST;
      aux_cfg <= `DSPLI_CFG_RST;
      in_cfg <= `DSPLI_IN_CFG_RST;
      in_wait <= 32'h00000000;
      host_wr <= 2'b00;
      host_char <= 8'h00;
      settle <= 10'h000;
    end else begin
      host_wr <= 2'b00;
      if (settling && ms_tick) settle <= settle - 10'h001;
      if (wr_ph && !a_q[9]) begin
        case (a_q)
          `DSPLI_PRI_CFG: pri_cfg <= {2'b00, hwdata[8:0]};
          `DSPLI_AUX_CFG: begin
            aux_cfg <= hwdata[10:0];
            if (hwdata[`DSPLI_F_IFACE] != aux_cfg[`DSPLI_F_IFACE])
              settle <= `DSPLI_SETTLE_MS;
          end
          `DSPLI_IN_CFG: in_cfg <= hwdata[22:0];
          `DSPLI_IN_WAIT: in_wait <= hwdata;
          `DSPLI_TX_DATA: begin
            host_wr <= hwdata[`DSPLI_F_TXAUX] ? 2'b10 : 2'b01;
            host_char <= hwdata[7:0];
          end
          default: host_wr <= 2'b00;
        endcase
      end
    end
  end

  // ========================================================================
  // Line input
  wire [7:0] lch = rx_char[lport];
  wire lhit = rx_v[lport];
  wire [6:0] llen = in_cfg[`DSPLI_F_LEN];
  wire len_on = (llen != 7'd0) && (llen <= `DSPLI_MAX_LEN);
  wire is_edit = !in_cfg[`DSPLI_F_NOEDIT] && (lch == `DSPLI_CH_BS || lch == `DSPLI_CH_DEL);
  wire store = (lstate == S_RUN) && lhit && (lch != in_cfg[`DSPLI_F_TERM]) && !is_edit
    && (lcnt < `DSPLI_BUF_DEPTH);
  wire start = wr_ph && (a_q == `DSPLI_IN_CTRL) && hwdata[`DSPLI_F_START];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lstate <= S_IDLE;
      lport <= 1'b0;
      lcnt <= 7'h00;
      got <= 1'b0;
      wait_ms <= 16'h0000;
      why <= 4'h0;
      echo_req <= 2'b00;
      echo_char <= 8'h00;
    end else begin
      echo_req <= 2'b00;
      case (lstate)
        S_IDLE: begin
          if (start) begin
            lstate <= S_RUN;
            lport <= hwdata[`DSPLI_F_LPORT];
            lcnt <= 7'h00;
            got <= 1'b0;
            wait_ms <= 16'h0000;
            why <= 4'h0;
          end
        end
        S_RUN: begin
          if (lhit) begin
            got <= 1'b1;
            wait_ms <= 16'h0000;
            echo_req[lport] <= !in_cfg[`DSPLI_F_NOECHO];
            echo_char <= lch;
            if (lch == in_cfg[`DSPLI_F_TERM]) begin
              lstate <= S_IDLE;
              why <= `DSPLI_WHY_TERM;
            end else if (is_edit) begin
              if (lcnt != 7'h00) lcnt <= lcnt - 7'h01;
            end else if (store) begin
              lcnt <= lcnt + 7'h01;
              if (len_on && (lcnt + 7'h01 == llen)) begin
                lstate <= S_IDLE;
                why <= `DSPLI_WHY_LEN;
              end
            end
          end else begin
            if (ms_tick) wait_ms <= wait_ms + 16'h0001;
            if (!got && in_wait[`DSPLI_F_FIRST] != 16'h0000
                && wait_ms >= in_wait[`DSPLI_F_FIRST]) begin
              lstate <= S_IDLE;
              why <= `DSPLI_WHY_FIRST;
            end
            if (got && in_wait[`DSPLI_F_NEXT] != 16'h0000
                && wait_ms >= in_wait[`DSPLI_F_NEXT]) begin
              lstate <= S_IDLE;
              why <= `DSPLI_WHY_NEXT;
            end
          end
        end
        default: lstate <= S_IDLE;
      endcase
    end
  end

  dspli_line_mem u_mem (
    .clk(clk),
    .wen(store),
    .waddr(lcnt),
    .wdata(lch),
    .raddr(haddr[8:2]),
    .q(mem_q)
  );
endmodule
`default_nettype wire
